// ==== design/tmcf_params.svh ====
// offsets, field positions, reset values and divider taps of the 8-bit timer
// assumes inclusion by bare name from every file that decodes timer registers
`ifndef TMCF_PARAMS_SVH
`define TMCF_PARAMS_SVH

// register byte offsets on the APB word grid
`define TMCF_OFS_CTRL_A 8'h00
`define TMCF_OFS_CTRL_B 8'h04
`define TMCF_OFS_COUNT 8'h08
`define TMCF_OFS_CMP_A 8'h0C
`define TMCF_OFS_CMP_B 8'h10
`define TMCF_OFS_MASK 8'h14
`define TMCF_OFS_FLAGS 8'h18

// control A fields
`define TMCF_CA_OUT_MODE_A 7:6
`define TMCF_CA_OUT_MODE_B 5:4
`define TMCF_CA_WAVE_LOW 1:0
// control B fields
`define TMCF_CB_FORCE_A 7
`define TMCF_CB_FORCE_B 6
`define TMCF_CB_WAVE_MSB 3
`define TMCF_CB_CLOCK_SEL 2:0
// readable bits of control A and control B
`define TMCF_CA_READ_MASK 8'hF3
`define TMCF_CB_READ_MASK 8'h0F
// mask and flag bit positions
`define TMCF_BIT_CMP_B 2
`define TMCF_BIT_CMP_A 1
`define TMCF_BIT_OVF 0

// reset values
`define TMCF_RST_BYTE 8'h00
`define TMCF_RST_FLAGS 3'h0

// fixed counter levels
`define TMCF_CNT_MAX 8'hFF
`define TMCF_CNT_BOTTOM 8'h00

// prescaler taps: a tick when the low bits of the free counter are all ones
`define TMCF_TAP_DIV8 10'h007
`define TMCF_TAP_DIV64 10'h03F
`define TMCF_TAP_DIV256 10'h0FF
`define TMCF_TAP_DIV1024 10'h3FF

`endif

// ==== design/tmcf_pkg.sv ====
// types shared by the timer core and its clock-select stage
// assumes the constants come from tmcf_params.svh
package tmcf_pkg;

	// clock select encodings
	typedef enum logic [2:0]
	{
		CS_STOP = 3'h0,
		CS_DIV1 = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} tmcf_clock_sel_t;

	// decoded counting behaviour
	typedef enum
	{
		KIND_NORMAL,
		KIND_CTC,
		KIND_FAST,
		KIND_PHASE
	} tmcf_kind_t;

endpackage

// ==== design/tmcf_clk_if.sv ====
// carrier between the register core and the clock-select stage
// assumes both ends sit on CLK_SYS
`timescale 1ns/100ps

interface tmcf_clk_if;
	tmcf_pkg::tmcf_clock_sel_t clock_select;
	logic tick;

	modport core
	(
		output clock_select,
		input tick
	);

	modport select
	(
		input clock_select,
		output tick
	);
endinterface

// ==== design/tmcf_clock_select.sv ====
// prescaler and external pin edge detector that make the timer tick enable
// assumes ext_count_pin is asynchronous and clk_sys is the I/O clock
`timescale 1ns/100ps
`include "tmcf_params.svh"

module tmcf_clock_select
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ext_count_pin,
	tmcf_clk_if.select cs_if
);
	logic [9:0] presc_q;
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic ext_rise;
	logic ext_fall;

	// free prescaler; shared by all taps, so a new select does not restart it
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			presc_q <= 10'h000;
		else
			presc_q <= presc_q + 10'h001;
	end

	// two-flop synchroniser, then a third flop for edge detection
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= ext_count_pin;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// pin edges count whatever the pin direction
	assign ext_rise = sync2_q & ~prev_q;
	assign ext_fall = ~sync2_q & prev_q;

	always_comb
	begin
		case (cs_if.clock_select)
			tmcf_pkg::CS_STOP: cs_if.tick = 1'b0;
			tmcf_pkg::CS_DIV1: cs_if.tick = 1'b1;
			tmcf_pkg::CS_DIV8: cs_if.tick = (presc_q & `TMCF_TAP_DIV8) == `TMCF_TAP_DIV8;
			tmcf_pkg::CS_DIV64: cs_if.tick = (presc_q & `TMCF_TAP_DIV64) == `TMCF_TAP_DIV64;
			tmcf_pkg::CS_DIV256: cs_if.tick = (presc_q & `TMCF_TAP_DIV256) == `TMCF_TAP_DIV256;
			tmcf_pkg::CS_DIV1024: cs_if.tick = presc_q == `TMCF_TAP_DIV1024;
			tmcf_pkg::CS_EXT_FALL: cs_if.tick = ext_fall;
			tmcf_pkg::CS_EXT_RISE: cs_if.tick = ext_rise;
			default: cs_if.tick = 1'b0;
		endcase
	end
endmodule

// ==== design/tmcf_timer8.sv ====
// 8-bit timer/counter with two compare channels, mask and flag registers
// assumes an APB master on CLK_SYS and CPU interrupt logic on the same clock
`timescale 1ns/100ps
`include "tmcf_params.svh"

module tmcf_timer8
(
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXT_COUNT_PIN,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic [2:0] VECTOR_ACK,
	output logic IRQ_OVERFLOW,
	output logic IRQ_COMPARE_A,
	output logic IRQ_COMPARE_B,
	output logic WAVE_OUT_A,
	output logic WAVE_OUT_B,
	output logic WAVE_OE_A,
	output logic WAVE_OE_B
);
	logic [7:0] ctrl_a_q;
	logic [3:0] ctrl_b_q;
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic [7:0] cmp_a_q;
	logic [7:0] cmp_b_q;
	logic [2:0] mask_q;
	logic [2:0] flags_q;
	logic [2:0] flags_d;
	logic up_q;
	logic up_d;
	logic block_q;
	logic wave_a_q;
	logic wave_b_q;
	logic [31:0] prdata_q;

	tmcf_clk_if cs_if ();

	tmcf_clock_select u_clock_select
	(
		.clk_sys(CLK_SYS),
		.rst_n(RSTN),
		.ext_count_pin(EXT_COUNT_PIN),
		.cs_if(cs_if)
	);

	// bus decode
	wire setup = PSEL & ~PENABLE;
	wire wr_en = PSEL & PENABLE & PWRITE;
	wire [7:0] wbyte = PWDATA[7:0];
	wire hit_ctrl_a = PADDR == `TMCF_OFS_CTRL_A;
	wire hit_ctrl_b = PADDR == `TMCF_OFS_CTRL_B;
	wire hit_count = PADDR == `TMCF_OFS_COUNT;
	wire hit_cmp_a = PADDR == `TMCF_OFS_CMP_A;
	wire hit_cmp_b = PADDR == `TMCF_OFS_CMP_B;
	wire hit_mask = PADDR == `TMCF_OFS_MASK;
	wire hit_flags = PADDR == `TMCF_OFS_FLAGS;
	wire wr_ctrl_b = wr_en & hit_ctrl_b;
	wire wr_count = wr_en & hit_count;

	// zero-wait slave; an unmapped address reads zero and is not an error
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = prdata_q;

	// mode bits split over both control registers
	wire [2:0] wave_mode = {ctrl_b_q[`TMCF_CB_WAVE_MSB], ctrl_a_q[`TMCF_CA_WAVE_LOW]};
	wire [1:0] out_mode_a = ctrl_a_q[`TMCF_CA_OUT_MODE_A];
	wire [1:0] out_mode_b = ctrl_a_q[`TMCF_CA_OUT_MODE_B];
	wire wave_msb = ctrl_b_q[`TMCF_CB_WAVE_MSB];
	assign cs_if.clock_select = tmcf_pkg::tmcf_clock_sel_t'(ctrl_b_q[`TMCF_CB_CLOCK_SEL]);

	// decode the counting behaviour; reserved codes run as normal
	tmcf_pkg::tmcf_kind_t kind;
	always_comb
	begin
		case (wave_mode)
			3'h1: kind = tmcf_pkg::KIND_PHASE;
			3'h2: kind = tmcf_pkg::KIND_CTC;
			3'h3: kind = tmcf_pkg::KIND_FAST;
			3'h5: kind = tmcf_pkg::KIND_PHASE;
			3'h7: kind = tmcf_pkg::KIND_FAST;
			default: kind = tmcf_pkg::KIND_NORMAL;
		endcase
	end

	wire is_pwm = (kind == tmcf_pkg::KIND_FAST) || (kind == tmcf_pkg::KIND_PHASE);
	wire top_from_a = (kind == tmcf_pkg::KIND_CTC) || wave_msb;
	wire [7:0] top = top_from_a ? cmp_a_q : `TMCF_CNT_MAX;
	wire tick = cs_if.tick;
	wire at_top = count_q == top;
	wire at_bottom = count_q == `TMCF_CNT_BOTTOM;

	// continuous compare; held off for one tick after a counter write
	wire match_a = tick & ~block_q & (count_q == cmp_a_q);
	wire match_b = tick & ~block_q & (count_q == cmp_b_q);

	// force only in non-PWM modes; ignored in PWM
	wire force_a = wr_ctrl_b & wbyte[`TMCF_CB_FORCE_A] & ~is_pwm;
	wire force_b = wr_ctrl_b & wbyte[`TMCF_CB_FORCE_B] & ~is_pwm;

	// overflow point per mode; max, bottom or top
	logic ovf_evt;
	always_comb
	begin
		case (kind)
			tmcf_pkg::KIND_PHASE: ovf_evt = tick & at_bottom & ~up_q;
			tmcf_pkg::KIND_FAST: ovf_evt = tick & at_top;
			default: ovf_evt = tick & (count_q == `TMCF_CNT_MAX);
		endcase
	end

	// counter sequencing; a bus write always wins over a tick
	always_comb
	begin
		count_d = count_q;
		up_d = up_q;
		if (wr_count)
			count_d = wbyte;
		else if (tick)
		begin
			case (kind)
				// clearing here follows count equal to compare a, blocked match or not, never a force
				tmcf_pkg::KIND_CTC: count_d = (match_a | at_top) ? `TMCF_CNT_BOTTOM : count_q + 8'h01;
				tmcf_pkg::KIND_FAST: count_d = at_top ? `TMCF_CNT_BOTTOM : count_q + 8'h01;
				tmcf_pkg::KIND_PHASE:
				begin
					if (up_q && at_top)
					begin
						up_d = 1'b0;
						count_d = count_q - 8'h01;
					end
					else if (!up_q && at_bottom)
					begin
						up_d = 1'b1;
						count_d = count_q + 8'h01;
					end
					else
						count_d = up_q ? count_q + 8'h01 : count_q - 8'h01;
				end
				default: count_d = count_q + 8'h01;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			count_q <= `TMCF_RST_BYTE;
			up_q <= 1'b1;
		end
		else
		begin
			count_q <= count_d;
			up_q <= up_d;
		end
	end

	// a counter write blocks matches until the next timer tick
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			block_q <= 1'b0;
		else if (wr_count)
			block_q <= 1'b1;
		else if (tick)
			block_q <= 1'b0;
	end

	// next waveform level for one channel
	function automatic logic wave_next(input logic cur, input logic [1:0] om,
		input tmcf_pkg::tmcf_kind_t k, input logic hit, input logic frc,
		input logic wrap, input logic up, input logic tog_ok);
		logic r;
		r = cur;
		case (k)
			// off, toggle, clear, set on a match, or on a force outside the PWM modes
			tmcf_pkg::KIND_FAST:
			begin
				if (hit && om == 2'h1 && tog_ok)
					r = ~cur;
				else if (hit && om[1])
					r = om[0];
				else if (wrap && om[1])
					r = ~om[0];
			end
			tmcf_pkg::KIND_PHASE:
			begin
				if (hit && om == 2'h1 && tog_ok)
					r = ~cur;
				else if (hit && om[1])
					r = om[0] ~^ up;
			end
			default:
			begin
				if ((hit || frc) && om == 2'h1)
					r = ~cur;
				else if ((hit || frc) && om[1])
					r = om[0];
			end
		endcase
		return r;
	endfunction

	// wrap into bottom in fast PWM: set or clear the output there
	wire fast_wrap = tick & at_top;

	// force and match share the output action; match drives pins
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wave_a_q <= 1'b0;
			wave_b_q <= 1'b0;
		end
		else
		begin
			wave_a_q <= wave_next(wave_a_q, out_mode_a, kind, match_a, force_a,
				fast_wrap, up_q, wave_msb);
			wave_b_q <= wave_next(wave_b_q, out_mode_b, kind, match_b, force_b,
				fast_wrap, up_q, 1'b0);
		end
	end

	// output connects whenever its mode is not disconnected
	assign WAVE_OUT_A = wave_a_q;
	assign WAVE_OUT_B = wave_b_q;
	assign WAVE_OE_A = out_mode_a != 2'h0;
	assign WAVE_OE_B = out_mode_b != 2'h0;

	// compare flags set on real matches only; forces excluded
	wire [2:0] flag_set = {match_b, match_a, ovf_evt};
	// one clears, zero keeps; vector execution clears too
	wire [2:0] flag_clr = ({3{wr_en & hit_flags}} & wbyte[2:0]) | VECTOR_ACK;
	// a set in the clearing cycle survives
	assign flags_d = (flags_q & ~flag_clr) | flag_set;

	// all software registers start at zero
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ctrl_a_q <= `TMCF_RST_BYTE;
			ctrl_b_q <= 4'h0;
			cmp_a_q <= `TMCF_RST_BYTE;
			cmp_b_q <= `TMCF_RST_BYTE;
			mask_q <= `TMCF_RST_FLAGS;
			flags_q <= `TMCF_RST_FLAGS;
		end
		else
		begin
			flags_q <= flags_d;
			if (wr_en && hit_ctrl_a)
				ctrl_a_q <= wbyte & `TMCF_CA_READ_MASK;
			if (wr_ctrl_b)
				ctrl_b_q <= wbyte[3:0];
			if (wr_en && hit_cmp_a)
				cmp_a_q <= wbyte;
			if (wr_en && hit_cmp_b)
				cmp_b_q <= wbyte;
			if (wr_en && hit_mask)
				mask_q <= wbyte[2:0];
		end
	end

	// each request needs mask, flag and the global enable
	assign IRQ_OVERFLOW = GLOBAL_IRQ_ENABLE & mask_q[`TMCF_BIT_OVF] & flags_q[`TMCF_BIT_OVF];
	assign IRQ_COMPARE_A = GLOBAL_IRQ_ENABLE & mask_q[`TMCF_BIT_CMP_A]
		& flags_q[`TMCF_BIT_CMP_A];
	assign IRQ_COMPARE_B = GLOBAL_IRQ_ENABLE & mask_q[`TMCF_BIT_CMP_B]
		& flags_q[`TMCF_BIT_CMP_B];

	// read mux; force bits and reserved bits come back zero
	logic [7:0] rd_byte;
	always_comb
	begin
		rd_byte = 8'h00;
		if (hit_ctrl_a)
			rd_byte = ctrl_a_q;
		else if (hit_ctrl_b)
			rd_byte = {4'h0, ctrl_b_q};
		else if (hit_count)
			rd_byte = count_q;
		else if (hit_cmp_a)
			rd_byte = cmp_a_q;
		else if (hit_cmp_b)
			rd_byte = cmp_b_q;
		else if (hit_mask)
			rd_byte = {5'h00, mask_q};
		else if (hit_flags)
			rd_byte = {5'h00, flags_q};
	end

	// read data captured in the setup cycle, so it stands through the access
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			prdata_q <= 32'h0000_0000;
		else if (setup)
			prdata_q <= {24'h000000, rd_byte};
	end
endmodule

// ==== dv/tmcf_timer8_checker.sv ====
// port assertions for the timer top: apb reads, interrupts, outputs
// assumes binding to tmcf_timer8, everything on CLK_SYS
`timescale 1ns/100ps
`include "tmcf_params.svh"

module tmcf_timer8_checker
(
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic IRQ_OVERFLOW,
	input wire logic IRQ_COMPARE_A,
	input wire logic WAVE_OUT_A,
	input wire logic WAVE_OE_A,
	input wire logic WAVE_OE_B
);
	// single domain, quiet during reset
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);

	// apb read setup and write access
	sequence s_rd(logic [7:0] a);
		PSEL && !PENABLE && !PWRITE && PADDR == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		PSEL && PENABLE && PWRITE && PADDR == a;
	endsequence

	// read data loaded at setup edge, so judged one cycle on
	property p_ctrl_b_zero;
		s_rd(`TMCF_OFS_CTRL_B) |=> PRDATA[7:4] == 4'h0;
	endproperty
	a_ctrl_b_zero: assert property (p_ctrl_b_zero)
		else $error("control b strobe or reserved bit read high");
	property p_mask_zero;
		s_rd(`TMCF_OFS_MASK) |=> PRDATA[7:3] == 5'h00;
	endproperty
	a_mask_zero: assert property (p_mask_zero)
		else $error("mask reserved bits read high");
	property p_flag_zero;
		s_rd(`TMCF_OFS_FLAGS) |=> PRDATA[7:3] == 5'h00;
	endproperty
	a_flag_zero: assert property (p_flag_zero)
		else $error("flag reserved bits read high");

	// no overflow or compare a request without the global enable; no compare a request while masked
	property p_gie_o;
		!GLOBAL_IRQ_ENABLE |-> !IRQ_OVERFLOW;
	endproperty
	a_gie_o: assert property (p_gie_o)
		else $error("overflow request without global enable");
	property p_gie_a;
		!GLOBAL_IRQ_ENABLE |-> !IRQ_COMPARE_A;
	endproperty
	a_gie_a: assert property (p_gie_a)
		else $error("compare a request without global enable");
	property p_mask_a;
		s_wr(`TMCF_OFS_MASK) ##0 !PWDATA[1] |=> !IRQ_COMPARE_A;
	endproperty
	a_mask_a: assert property (p_mask_a)
		else $error("compare a request while masked");

	// pin driven exactly when its output mode is not off
	property p_oe_a;
		s_wr(`TMCF_OFS_CTRL_A) |=> WAVE_OE_A == ($past(PWDATA[7:6]) != 2'h0);
	endproperty
	a_oe_a: assert property (p_oe_a)
		else $error("output a enable disagrees with its mode");
	property p_oe_b;
		s_wr(`TMCF_OFS_CTRL_A) |=> WAVE_OE_B == ($past(PWDATA[5:4]) != 2'h0);
	endproperty
	a_oe_b: assert property (p_oe_b)
		else $error("output b enable disagrees with its mode");

	// channel a wave and enable, overflow and compare a requests idle at the first edge after release
	property p_reset;
		$rose(RSTN) |-> !WAVE_OUT_A && !WAVE_OE_A && !IRQ_OVERFLOW && !IRQ_COMPARE_A;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs active straight after reset");
endmodule

bind tmcf_timer8 tmcf_timer8_checker i_chk
(
	.CLK_SYS(CLK_SYS),
	.RSTN(RSTN),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PWDATA(PWDATA),
	.PRDATA(PRDATA),
	.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
	.IRQ_OVERFLOW(IRQ_OVERFLOW),
	.IRQ_COMPARE_A(IRQ_COMPARE_A),
	.WAVE_OUT_A(WAVE_OUT_A),
	.WAVE_OE_A(WAVE_OE_A),
	.WAVE_OE_B(WAVE_OE_B)
);

// ==== dv/timer8_control_and_flags_tb.sv ====
// self-checking bench for the 8-bit timer, apb master inside
// assumes a zero-wait apb slave; the bench drives every pin itself
`timescale 1ns/100ps
`include "tmcf_params.svh"

module timer8_control_and_flags_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic ext_pin = 1'b0;
	logic gie = 1'b0;
	logic [2:0] vack = 3'h0;
	logic [31:0] prdata;
	logic pready;
	logic irq_o;
	logic irq_a;
	logic irq_b;
	logic wo_a;
	logic wo_b;
	logic oe_a;
	logic [31:0] q;
	int errors = 0;
	int num_checks = 0;

	tmcf_timer8 i_dut
	(
		.CLK_SYS(clk),
		.RSTN(rst_n),
		.PSEL(psel),
		.PENABLE(penable),
		.PWRITE(pwrite),
		.PADDR(paddr),
		.PWDATA(pwdata),
		.PRDATA(prdata),
		.PREADY(pready),
		.PSLVERR(),
		.EXT_COUNT_PIN(ext_pin),
		.GLOBAL_IRQ_ENABLE(gie),
		.VECTOR_ACK(vack),
		.IRQ_OVERFLOW(irq_o),
		.IRQ_COMPARE_A(irq_a),
		.IRQ_COMPARE_B(irq_b),
		.WAVE_OUT_A(wo_a),
		.WAVE_OUT_B(wo_b),
		.WAVE_OE_A(oe_a),
		.WAVE_OE_B()
	);

	// 50 ns clock
	initial
	begin
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// access phase held until pready; one idle edge keeps drives apart
	task automatic acc();
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			@(posedge clk);
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		acc();
	endtask

	task automatic rd(input logic [7:0] a);
		psel <= 1'b1;
		paddr <= a;
		@(posedge clk);
		acc();
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(nm, {24'h0, e}, q);
	endtask

	// force both channels under a given control a setting
	task automatic frc(input logic [7:0] ca, input logic ea, input logic eb);
		wr(`TMCF_OFS_CTRL_A, ca);
		wr(`TMCF_OFS_CTRL_B, 8'hC0);
		chk("wave_out_a", ea, wo_a);
		chk("wave_out_b", eb, wo_b);
	endtask

	task automatic t_reset();
		for (int i = 0; i < 8; i++)
		begin
			rdchk("reset value", 8'(i * 4), 8'h00);
		end
		chk("wave_oe_a", 1'b0, oe_a);
		wr(8'h1C, 8'hFF);
		rdchk("unmapped", 8'h1C, 8'h00);
		wr(`TMCF_OFS_CTRL_B, 8'hF8);
		rdchk("ctrl_b", `TMCF_OFS_CTRL_B, 8'h08);
		wr(`TMCF_OFS_MASK, 8'hFF);
		rdchk("mask", `TMCF_OFS_MASK, 8'h07);
		wr(`TMCF_OFS_CTRL_B, 8'h00);
		wr(`TMCF_OFS_MASK, 8'h00);
		wr(`TMCF_OFS_CMP_A, 8'hA5);
		rdchk("cmp_a", `TMCF_OFS_CMP_A, 8'hA5);
		$display("t_reset done");
	endtask

	task automatic t_force();
		wr(`TMCF_OFS_COUNT, 8'h09);
		frc(8'h50, 1'b1, 1'b1);
		frc(8'hA0, 1'b0, 1'b0);
		frc(8'hF0, 1'b1, 1'b1);
		frc(8'h50, 1'b0, 1'b0);
		frc(8'hF2, 1'b1, 1'b1);
		frc(8'hA3, 1'b1, 1'b1);
		frc(8'hA1, 1'b1, 1'b1);
		rdchk("count", `TMCF_OFS_COUNT, 8'h09);
		rdchk("flags", `TMCF_OFS_FLAGS, 8'h00);
		wr(`TMCF_OFS_CTRL_A, 8'h00);
		$display("t_force done");
	endtask

	task automatic t_match();
		wr(`TMCF_OFS_COUNT, 8'h00);
		wr(`TMCF_OFS_CMP_A, 8'h03);
		wr(`TMCF_OFS_CMP_B, 8'h05);
		wr(`TMCF_OFS_MASK, 8'h07);
		gie <= 1'b1;
		wr(`TMCF_OFS_CTRL_B, 8'h01);
		cyc(12);
		wr(`TMCF_OFS_CTRL_B, 8'h00);
		rdchk("flags", `TMCF_OFS_FLAGS, 8'h06);
		chk("irq_a", 1'b1, irq_a);
		chk("irq_o", 1'b0, irq_o);
		gie <= 1'b0;
		cyc(1);
		chk("irq_b", 1'b0, irq_b);
		gie <= 1'b1;
		wr(`TMCF_OFS_MASK, 8'h05);
		chk("irq_a", 1'b0, irq_a);
		chk("irq_b", 1'b1, irq_b);
		wr(`TMCF_OFS_FLAGS, 8'h00);
		rdchk("flags", `TMCF_OFS_FLAGS, 8'h06);
		wr(`TMCF_OFS_FLAGS, 8'h02);
		rdchk("flags", `TMCF_OFS_FLAGS, 8'h04);
		vack <= 3'h4;
		cyc(1);
		vack <= 3'h0;
		rdchk("flags", `TMCF_OFS_FLAGS, 8'h00);
		wr(`TMCF_OFS_COUNT, 8'hFC);
		wr(`TMCF_OFS_CTRL_B, 8'h01);
		cyc(4);
		wr(`TMCF_OFS_CTRL_B, 8'h00);
		chk("irq_o", 1'b1, irq_o);
		vack <= 3'h1;
		cyc(1);
		vack <= 3'h0;
		cyc(1);
		chk("irq_o", 1'b0, irq_o);
		$display("t_match done");
	endtask

	// counter write hides the match at the very next tick
	task automatic t_block();
		wr(`TMCF_OFS_FLAGS, 8'h07);
		wr(`TMCF_OFS_CMP_B, 8'h40);
		wr(`TMCF_OFS_COUNT, 8'h40);
		wr(`TMCF_OFS_CTRL_B, 8'h01);
		cyc(4);
		wr(`TMCF_OFS_CTRL_B, 8'h00);
		rdchk("flags", `TMCF_OFS_FLAGS, 8'h00);
		$display("t_block done");
	endtask

	// fast then phase pwm, compare a as top of 4; 23 ticks from 0 land on 3 and 1
	task automatic t_pwm();
		for (int m = 0; m < 2; m++)
		begin
			wr(`TMCF_OFS_FLAGS, 8'h07);
			wr(`TMCF_OFS_COUNT, 8'h00);
			wr(`TMCF_OFS_CMP_A, 8'h04);
			wr(`TMCF_OFS_CTRL_A, m ? 8'h01 : 8'h03);
			// force bits kept zero while a pwm mode is selected
			wr(`TMCF_OFS_CTRL_B, 8'h09);
			cyc(20);
			wr(`TMCF_OFS_CTRL_B, 8'h08);
			rdchk("pwm count", `TMCF_OFS_COUNT, m ? 8'h01 : 8'h03);
			rdchk("pwm flags", `TMCF_OFS_FLAGS, 8'h03);
		end
		wr(`TMCF_OFS_CTRL_A, 8'h00);
		wr(`TMCF_OFS_CTRL_B, 8'h00);
		$display("t_pwm done");
	endtask

	// four periods of each divider leave four to seven ticks
	task automatic t_presc();
		int dv[6] = '{0, 1, 8, 64, 256, 1024};
		for (int cs = 1; cs < 6; cs++)
		begin
			wr(`TMCF_OFS_COUNT, 8'h00);
			wr(`TMCF_OFS_CTRL_B, 8'(cs));
			cyc(dv[cs] * 4 - 1);
			wr(`TMCF_OFS_CTRL_B, 8'h00);
			rd(`TMCF_OFS_COUNT);
			chk("ticks in range", 1'b1, q >= 32'h4 && q <= 32'h7);
		end
		cyc(10);
		rdchk("stopped count", `TMCF_OFS_COUNT, q[7:0]);
		$display("t_presc done");
	endtask

	// five toggles from low: three rising and two falling edges
	task automatic t_ext();
		for (int cs = 6; cs < 8; cs++)
		begin
			ext_pin <= 1'b0;
			wr(`TMCF_OFS_COUNT, 8'h00);
			wr(`TMCF_OFS_CTRL_B, 8'(cs));
			repeat (5)
			begin
				ext_pin <= ~ext_pin;
				cyc(4);
			end
			wr(`TMCF_OFS_CTRL_B, 8'h00);
			rdchk("ext edges", `TMCF_OFS_COUNT, 8'(cs - 4));
		end
		$display("t_ext done");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// reset three cycles, then the scenarios
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_force();
		t_match();
		t_block();
		t_pwm();
		t_presc();
		t_ext();
		final_report();
	end

	// watchdog, well past the roughly six thousand cycles needed
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report();
	end
endmodule
